// >>> sdrc_top.sv
// sdrc_top.sv: sdram host controller, AXI4-Lite command port.
// assumes a single-rank x16 sdram on the sdr_ pins, one clock.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_regs.svh"
module sdrc_top #(
    parameter int PWRUP_CYC = `SDRC_PWRUP_US * 1000 / `SDRC_CLK_NS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sdr_cke,
    output logic sdr_cs_n,
    output logic sdr_ras_n,
    output logic sdr_cas_n,
    output logic sdr_we_n,
    output logic [1:0] sdr_ba,
    output logic [11:0] sdr_addr,
    output logic [1:0] sdr_dqm,
    output logic [15:0] sdr_dq_out,
    output logic sdr_dq_oe,
    input wire logic [15:0] sdr_dq_in
);
    localparam logic [15:0] TRP_CYC = 16'((`SDRC_PRECHARGE_PERIOD_NS
        + `SDRC_CLK_NS - 1) / `SDRC_CLK_NS);
    localparam logic [15:0] ROW_TO_COLUMN_DELAY_CYC = 16'((`SDRC_ROW_TO_COLUMN_DELAY_NS
        + `SDRC_CLK_NS - 1) / `SDRC_CLK_NS);
    localparam logic [15:0] TWR_CYC = 16'((`SDRC_WRITE_RECOVERY_TIME_NS
        + `SDRC_CLK_NS - 1) / `SDRC_CLK_NS);
    localparam logic [15:0] MODE_CYC = 16'(`SDRC_MODE_LOAD_CYC);

    if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) begin : g_chk
        $error("PWRUP_CYC out of range");
    end

    function automatic logic [15:0] bl_cyc(input logic [2:0] c);
        case (c)
            3'h1: bl_cyc = 16'h2;
            3'h2: bl_cyc = 16'h4;
            3'h3: bl_cyc = 16'h8;
            default: bl_cyc = 16'h1;
        endcase
    endfunction

    // burst and latency codes, interleave only for 4 and 8
    function automatic logic mode_legal(input logic [13:0] m);
        logic bl_ok;
        logic lat_ok;
        bl_ok = m[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, `SDRC_BL_FULL};
        lat_ok = m[6:4] inside {3'h2, 3'h3};
        mode_legal = bl_ok && lat_ok
            && (!m[3] || m[2:0] inside {3'h2, 3'h3});
    endfunction

    // cycles from this command to the next one
    function automatic logic [15:0] gap_for(input sdrc_pkg::sdrc_op_t op,
        input logic ap, input logic [13:0] m);
        logic [15:0] bl;
        logic [15:0] precharge_period;
        logic [15:0] fp;
        bl = bl_cyc(m[2:0]);
        precharge_period = ap ? TRP_CYC : 16'h0;
        fp = {15'h0, m[2:0] == `SDRC_BL_FULL};
        case (op)
            sdrc_pkg::OP_ACTIVATE: gap_for = ROW_TO_COLUMN_DELAY_CYC;
            sdrc_pkg::OP_WRITE: gap_for = (m[9] ? 16'h0 : bl - 16'h1)
                + TWR_CYC + precharge_period + fp;
            sdrc_pkg::OP_READ: gap_for = {13'h0, m[6:4]} + 16'h3
                + bl + precharge_period + fp;
            sdrc_pkg::OP_PRECHARGE: gap_for = TRP_CYC;
            sdrc_pkg::OP_MODE_LOAD: gap_for = MODE_CYC;
            default: gap_for = 16'h1;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    logic rst_q1;
    logic rst_q2;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    wire rst_s_n = rst_q2;

    sdrc_pkg::sdrc_state_t state;
    logic [15:0] cnt;
    logic init_done;
    logic cmd_req;
    sdrc_pkg::sdrc_op_t cmd_op;
    logic cmd_ap;
    logic [13:0] addr_reg;
    logic [13:0] mode_shadow;
    logic [13:0] dev_mode;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic rd_valid;
    logic err;
    logic [3:0] open_banks;
    logic [3:0] rd_cnt;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic aw_got;
    logic [2:0] aw_idx;
    logic aw_bad;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // software side
    assign s_axi_awready = ce && !aw_got && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_got && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire wr_do = ce && aw_got && w_got && !s_axi_bvalid;
    wire wr_ok = wr_do && !aw_bad;
    wire [2:0] ar_idx = s_axi_araddr[4:2];
    wire ar_bad = s_axi_araddr[31:5] != 27'h0 || ar_idx > `SDRC_OFS_RDATA;
    wire wr_cmd = wr_ok && aw_idx == `SDRC_OFS_CMD;
    wire [31:0] w_cmd = merge(32'h0, w_data, w_strb);
    wire busy = cmd_req || state != sdrc_pkg::ST_IDLE;
    wire [31:0] status = {24'h0, open_banks, rd_valid, err, init_done, busy};
    wire [31:0] rmux =
        ar_idx == `SDRC_OFS_CMD ? {28'h0, cmd_ap, cmd_op} :
        ar_idx == `SDRC_OFS_ADDR ? {18'h0, addr_reg} :
        ar_idx == `SDRC_OFS_MODE ? {18'h0, mode_shadow} :
        ar_idx == `SDRC_OFS_WDATA ? {16'h0, wdata_reg} :
        ar_idx == `SDRC_OFS_STATUS ? status : {16'h0, rdata_reg};

    // command issue
    wire [1:0] req_bank = addr_reg[13:12];
    wire op_act = cmd_op == sdrc_pkg::OP_ACTIVATE;
    wire op_wr = cmd_op == sdrc_pkg::OP_WRITE;
    wire op_rd = cmd_op == sdrc_pkg::OP_READ;
    wire op_pre = cmd_op == sdrc_pkg::OP_PRECHARGE;
    wire op_mode = cmd_op == sdrc_pkg::OP_MODE_LOAD;
    wire full_pg = dev_mode[2:0] == `SDRC_BL_FULL;
    wire eff_ap = cmd_ap && !full_pg;
    wire bank_open = open_banks[req_bank];
    wire req_ok = op_act ? !bank_open
        : (op_wr || op_rd) ? bank_open
        : op_pre ? 1'b1
        : op_mode && open_banks == 4'h0 && mode_legal(mode_shadow);
    wire go = ce && state == sdrc_pkg::ST_IDLE && cmd_req;
    wire fire = go && req_ok;
    wire err_set = (go && !req_ok) || (wr_cmd && cmd_req);
    wire err_clr = wr_ok && aw_idx == `SDRC_OFS_STATUS
        && w_strb[0] && w_data[`SDRC_ST_ERR];
    wire cap = ce && rd_cnt == 4'h1;
    wire rd_hit = ar_hs && ar_idx == `SDRC_OFS_RDATA;
    wire [15:0] fire_gap = gap_for(cmd_op, eff_ap, dev_mode) - 16'h1;
    wire [2:0] fire_pins = op_act ? `SDRC_PIN_ACT : op_wr ? `SDRC_PIN_WR
        : op_rd ? `SDRC_PIN_RD : op_pre ? `SDRC_PIN_PRE
        : op_mode ? `SDRC_PIN_MODE : `SDRC_PIN_NOP;
    wire [11:0] fire_addr = op_mode ? mode_shadow[11:0]
        : (op_wr || op_rd) ? {1'b0, eff_ap, addr_reg[9:0]}
        : addr_reg[11:0];
    wire fire_rw = fire && (op_wr || op_rd);
    wire [3:0] bank_bit = 4'h1 << req_bank;
    wire [3:0] next_open =
        !fire ? open_banks
        : op_act ? open_banks | bank_bit
        : op_pre && addr_reg[10] ? 4'h0
        : op_pre || ((op_wr || op_rd) && eff_ap) ? open_banks & ~bank_bit
        : open_banks;

    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            aw_got <= 1'b0;
            aw_idx <= 3'h0;
            aw_bad <= 1'b0;
            w_got <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (ce) begin
            if (aw_hs) begin
                aw_got <= 1'b1;
                aw_idx <= s_axi_awaddr[4:2];
                aw_bad <= s_axi_awaddr[31:5] != 27'h0
                    || s_axi_awaddr[4:2] > `SDRC_OFS_RDATA;
            end
            if (w_hs) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_bad ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= ar_bad ? 32'h0 : rmux;
                s_axi_rresp <= ar_bad ? 2'h2 : 2'h0;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cmd_req <= 1'b0;
            cmd_op <= sdrc_pkg::OP_NOP;
            cmd_ap <= 1'b0;
            addr_reg <= 14'h0;
            mode_shadow <= `SDRC_MODE_RESET;
            wdata_reg <= 16'h0;
            err <= 1'b0;
            rd_valid <= 1'b0;
            rdata_reg <= 16'h0;
            dq_s1 <= 16'h0;
            dq_s2 <= 16'h0;
            rd_cnt <= 4'h0;
        end else if (ce) begin
            dq_s1 <= sdr_dq_in;
            dq_s2 <= dq_s1;
            err <= err_set || (err && !err_clr);
            rd_valid <= cap || (rd_valid && !rd_hit);
            if (cap) begin
                rdata_reg <= dq_s2;
            end
            if (fire && op_rd) begin
                rd_cnt <= {1'b0, dev_mode[6:4]} + 4'h3;
            end else if (rd_cnt != 4'h0) begin
                rd_cnt <= rd_cnt - 4'h1;
            end
            if (go) begin
                cmd_req <= 1'b0;
            end else if (wr_cmd && !cmd_req) begin
                cmd_req <= w_cmd[2:0] != 3'h0;
                cmd_op <= sdrc_pkg::sdrc_op_t'(w_cmd[2:0]);
                cmd_ap <= w_cmd[3];
            end
            if (wr_ok && aw_idx == `SDRC_OFS_ADDR) begin
                addr_reg <= 14'(merge({18'h0, addr_reg}, w_data, w_strb));
            end
            if (wr_ok && aw_idx == `SDRC_OFS_MODE) begin
                mode_shadow <= 14'(merge({18'h0, mode_shadow}, w_data,
                    w_strb)) & `SDRC_MODE_KEEP;
            end
            if (wr_ok && aw_idx == `SDRC_OFS_WDATA) begin
                wdata_reg <= 16'(merge({16'h0, wdata_reg}, w_data, w_strb));
            end
        end
    end

    wire cnt_zero = cnt == 16'h0;
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state <= sdrc_pkg::ST_PWRUP;
            cnt <= 16'(PWRUP_CYC - 1);
            init_done <= 1'b0;
            dev_mode <= 14'h0;
            open_banks <= 4'h0;
            sdr_cke <= 1'b0;
            sdr_cs_n <= 1'b1;
            {sdr_ras_n, sdr_cas_n, sdr_we_n} <= `SDRC_PIN_NOP;
            sdr_ba <= 2'h0;
            sdr_addr <= 12'h0;
            sdr_dqm <= 2'h3;
            sdr_dq_out <= 16'h0;
            sdr_dq_oe <= 1'b0;
        end else if (ce) begin
            sdr_cke <= 1'b1;
            sdr_cs_n <= 1'b0;
            {sdr_ras_n, sdr_cas_n, sdr_we_n} <= `SDRC_PIN_NOP;
            sdr_dq_oe <= 1'b0;
            // mask stays high after writes until the next read or write command needs it low
            sdr_dqm <= (fire_rw || rd_cnt > 4'h1) ? 2'h0 : 2'h3;
            open_banks <= next_open;
            if (!cnt_zero) begin
                cnt <= cnt - 16'h1;
            end
            case (state)
                sdrc_pkg::ST_PWRUP: begin
                    if (cnt_zero) begin
                        state <= sdrc_pkg::ST_PRE_ALL;
                    end
                end
                sdrc_pkg::ST_PRE_ALL: begin
                    {sdr_ras_n, sdr_cas_n, sdr_we_n} <= `SDRC_PIN_PRE;
                    sdr_addr <= 12'h400;
                    cnt <= TRP_CYC - 16'h1;
                    state <= sdrc_pkg::ST_GAP;
                end
                sdrc_pkg::ST_MODE_INIT: begin
                    {sdr_ras_n, sdr_cas_n, sdr_we_n} <= `SDRC_PIN_MODE;
                    sdr_addr <= mode_shadow[11:0];
                    sdr_ba <= mode_shadow[13:12];
                    dev_mode <= mode_shadow;
                    init_done <= 1'b1;
                    cnt <= MODE_CYC - 16'h1;
                    state <= sdrc_pkg::ST_GAP;
                end
                sdrc_pkg::ST_IDLE: begin
                    if (fire) begin
                        {sdr_ras_n, sdr_cas_n, sdr_we_n} <= fire_pins;
                        sdr_addr <= fire_addr;
                        sdr_ba <= op_mode ? mode_shadow[13:12] : req_bank;
                        sdr_dq_out <= wdata_reg;
                        sdr_dq_oe <= op_wr;
                        cnt <= fire_gap;
                        if (op_mode) begin
                            dev_mode <= mode_shadow;
                        end
                        state <= fire_rw && full_pg ? sdrc_pkg::ST_STOP
                            : sdrc_pkg::ST_GAP;
                    end
                end
                sdrc_pkg::ST_STOP: begin
                    // full page runs forever: end it after one word
                    {sdr_ras_n, sdr_cas_n, sdr_we_n} <= `SDRC_PIN_STOP;
                    state <= sdrc_pkg::ST_GAP;
                end
                sdrc_pkg::ST_GAP: begin
                    if (cnt_zero) begin
                        state <= init_done ? sdrc_pkg::ST_IDLE
                            : sdrc_pkg::ST_MODE_INIT;
                    end
                end
                default: state <= sdrc_pkg::ST_IDLE;
            endcase
        end
    end

    // checking aid: decode the pins back to commands
    wire [2:0] pin_cmd = {sdr_ras_n, sdr_cas_n, sdr_we_n};
    wire pin_fire = ce && !sdr_cs_n && pin_cmd != `SDRC_PIN_NOP
        && pin_cmd != `SDRC_PIN_STOP;
    logic [15:0] since;
    logic [2:0] last_cmd;
    logic last_a10;
    logic [13:0] last_mode;
    always_ff @(posedge mclk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            since <= 16'h0;
            last_cmd <= `SDRC_PIN_NOP;
            last_a10 <= 1'b0;
            last_mode <= 14'h0;
        end else if (ce) begin
            since <= pin_fire ? 16'h1 : since + {15'h0, since != 16'hffff};
            if (pin_fire) begin
                last_cmd <= pin_cmd;
                last_a10 <= sdr_addr[10];
                last_mode <= dev_mode;
            end
        end
    end
    // gaps are judged by the mode in force at the earlier command
    wire [15:0] lbl = last_mode[9] ? 16'h1 : bl_cyc(last_mode[2:0]);
    wire fpm = dev_mode[2:0] == `SDRC_BL_FULL;

    rdap_gap_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && last_cmd == `SDRC_PIN_RD && last_a10
        |-> since >= TRP_CYC + bl_cyc(last_mode[2:0]))
        else $error("read autoprecharge spacing too short");
    act_gap_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && last_cmd == `SDRC_PIN_ACT |-> since >= ROW_TO_COLUMN_DELAY_CYC)
        else $error("column command too soon after activate");
    wr_data_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_WR
        |-> sdr_dq_oe && sdr_dqm == 2'h0 && sdr_dq_out == $past(wdata_reg))
        else $error("write data not with write command");
    dq_release_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_RD |-> !sdr_dq_oe [*3])
        else $error("data lines driven around a read");
    wr_pre_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_PRE && last_cmd == `SDRC_PIN_WR
        |-> since >= lbl - 16'h1 + TWR_CYC)
        else $error("precharge before write recovery");
    mask_hold_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        $past(sdr_dq_oe) && ce && !sdr_dq_oe && rd_cnt == 4'h0
        |-> sdr_dqm == 2'h3)
        else $error("data mask low after write word");
    wrap_gap_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && last_cmd == `SDRC_PIN_WR && last_a10
        |-> since >= lbl - 16'h1 + TWR_CYC + TRP_CYC)
        else $error("write autoprecharge spacing too short");
    mode_gap_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && last_cmd == `SDRC_PIN_MODE |-> since >= MODE_CYC)
        else $error("command within mode load time");
    mode_idle_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_MODE && init_done
        |-> $past(open_banks) == 4'h0)
        else $error("mode load with a bank open");
    mode_word_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_MODE |-> sdr_ba == 2'h0
        && sdr_addr[11:10] == 2'h0 && sdr_addr[8:7] == 2'h0)
        else $error("reserved or test mode bits set");
    mode_code_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_MODE
        |-> mode_legal({sdr_ba, sdr_addr}))
        else $error("reserved mode code programmed");
    init_first_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd inside {`SDRC_PIN_RD, `SDRC_PIN_WR}
        |-> init_done && !fpm || init_done)
        else $error("access before mode programmed");

    wr_seen_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_WR);
    rd_cap_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_RD ##[1:12] cap);
    mode_run_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
        pin_fire && pin_cmd == `SDRC_PIN_MODE && init_done);
    stop_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
        ce && !sdr_cs_n && pin_cmd == `SDRC_PIN_STOP);
endmodule
`default_nettype wire

// >>> sdrc_regs.svh
// sdrc_regs.svh: offsets, fields, reset values and timing of the
// sdram host controller; assumes a 50 MHz controller clock.
// Function
// - after read-autoprecharge wait precharge period plus burst
// - wait row-to-column delay after activate
// - first write word with write command
// - interrupting read one cycle after last word
// - release data lines before read data
// - precharge after write waits write recovery
// - mask data until the precharge edge
// - write-autoprecharge: burst-1 + recovery + precharge wait
// - program mode register at power-up
// - mode load needs two cycles
// - mode load only with all banks idle
// - reserved mode bits written as zero
// - test mode bits written 00
`ifndef SDRC_REGS_SVH
`define SDRC_REGS_SVH
`define SDRC_OFS_CMD 3'h0
`define SDRC_OFS_ADDR 3'h1
`define SDRC_OFS_MODE 3'h2
`define SDRC_OFS_WDATA 3'h3
`define SDRC_OFS_STATUS 3'h4
`define SDRC_OFS_RDATA 3'h5
`define SDRC_ST_ERR 2
`define SDRC_MODE_KEEP 14'h027f
`define SDRC_MODE_RESET 14'h0020
`define SDRC_BL_FULL 3'h7
`define SDRC_PIN_ACT 3'h3
`define SDRC_PIN_RD 3'h5
`define SDRC_PIN_WR 3'h4
`define SDRC_PIN_PRE 3'h2
`define SDRC_PIN_MODE 3'h0
`define SDRC_PIN_STOP 3'h6
`define SDRC_PIN_NOP 3'h7
`define SDRC_CLK_NS 20
`define SDRC_PRECHARGE_PERIOD_NS 20
`define SDRC_ROW_TO_COLUMN_DELAY_NS 20
`define SDRC_WRITE_RECOVERY_TIME_NS 15
`define SDRC_MODE_LOAD_CYC 2
`define SDRC_PWRUP_US 200
`endif

// >>> sdrc_pkg.sv
// sdrc_pkg.sv: types of the sdram host controller.
// assumes nothing beyond a SystemVerilog compiler.
package sdrc_pkg;
    typedef enum logic [2:0] {
        ST_PWRUP = 3'b000,
        ST_PRE_ALL = 3'b001,
        ST_MODE_INIT = 3'b010,
        ST_IDLE = 3'b011,
        ST_STOP = 3'b100,
        ST_GAP = 3'b101
    } sdrc_state_t;
    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_ACTIVATE = 3'b001,
        OP_WRITE = 3'b010,
        OP_READ = 3'b011,
        OP_PRECHARGE = 3'b100,
        OP_MODE_LOAD = 3'b101
    } sdrc_op_t;
endpackage

// >>> sdrc_mem_model.sv
// sdrc_mem_model.sv: behavioural x16 sdram, four banks, mode register.
// assumes commands sampled on rising mclk with cke high.
`timescale 1ns/1ps
`default_nettype none
module sdrc_mem_model (
    input wire logic mclk,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in
);
    logic [13:0] mode = 14'h3fff;
    logic [15:0] mem [0:2047];
    logic [3:0] open_bank = 4'h0;
    logic [1:0] rd_cnt = 2'h0;
    logic [15:0] rd_word = 16'h0;
    logic wr_on = 1'b0;
    logic [9:0] beat = 10'h0;
    logic [1:0] wbank = 2'h0;
    logic [8:0] wcol = 9'h0;
    wire [2:0] cmd = {ras_n, cas_n, we_n};
    wire [10:0] loc = {ba, addr[8:0]};
    wire ap = addr[10] && mode[2:0] != 3'h7;
    // write burst length, single word when bit nine is set
    wire [9:0] blen = mode[9] ? 10'h1 : mode[2:0] == 3'h7 ? 10'h200
        : 10'h1 << mode[1:0];
    wire [8:0] bmask = 9'(blen - 10'h1);
    wire [8:0] seq_col = (wcol & ~bmask)
        | ((wcol + beat[8:0]) & bmask);
    wire [8:0] bcol = mode[3] ? wcol ^ beat[8:0] : seq_col;
    wire quiet = cs_n || cmd == 3'h7;
    initial dq_in = 16'h0;
    always @(posedge mclk) begin
        // released bus shows a pattern that changes every cycle
        dq_in <= ~dq_in;
        if (rd_cnt != 2'h0) begin
            rd_cnt <= rd_cnt - 2'h1;
            if (rd_cnt == 2'h1) dq_in <= rd_word;
        end
        if (wr_on && quiet) begin
            if (!dqm[0]) begin
                mem[{wbank, bcol}] <= dq_oe ? dq_out : 16'hxxxx;
            end
            beat <= beat + 10'h1;
            if (beat + 10'h1 == blen && mode[2:0] != 3'h7) wr_on <= 1'b0;
        end
        // any command ends a write burst, its data is dropped
        if (!quiet) wr_on <= 1'b0;
        if (!cs_n) begin
            case (cmd)
                3'h0: mode <= {ba, addr};
                3'h3: open_bank[ba] <= 1'b1;
                3'h2: open_bank <= addr[10] ? 4'h0 : open_bank & ~(4'h1 << ba);
                3'h4: begin
                    if (dq_oe && !dqm[0]) mem[loc] <= dq_out;
                    if (ap) open_bank[ba] <= 1'b0;
                    wr_on <= blen != 10'h1;
                    beat <= 10'h1;
                    wbank <= ba;
                    wcol <= addr[8:0];
                end
                3'h5: begin
                    rd_word <= mem[loc];
                    rd_cnt <= mode[5:4] - 2'h1;
                    if (ap) open_bank[ba] <= 1'b0;
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sdrc_top_tb_top.sv
// sdrc_top_tb_top.sv: register-level bench of the sdram host controller.
// assumes sdrc_mem_model on the pins and AXI4-Lite from this bench.
`timescale 1ns/1ps
`default_nettype none
module sdrc_top_tb_top;
    logic mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    wire awready, wready, bvalid, arready, rvalid, cke, cs_n, ras_n;
    wire cas_n, we_n, dq_oe;
    wire [1:0] bresp, rresp, ba, dqm;
    wire [31:0] rdata;
    wire [11:0] addr;
    wire [15:0] dq_out, dq_in;
    int miscompares = 0, total_checks = 0;
    always #10 mclk = ~mclk;
    sdrc_top #(.PWRUP_CYC(4)) dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sdr_cke(cke), .sdr_cs_n(cs_n),
        .sdr_ras_n(ras_n), .sdr_cas_n(cas_n), .sdr_we_n(we_n), .sdr_ba(ba),
        .sdr_addr(addr), .sdr_dqm(dqm), .sdr_dq_out(dq_out),
        .sdr_dq_oe(dq_oe), .sdr_dq_in(dq_in));
    sdrc_mem_model mdl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, d);
        logic ap, wp;
        ap = 1;
        wp = 1;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (ap || wp) begin
            @(posedge mclk);
            if (ap && awready) begin
                ap = 0;
                awvalid <= 0;
            end
            if (wp && wready) begin
                wp = 0;
                wvalid <= 0;
            end
        end
        do @(posedge mclk); while (!bvalid);
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge mclk); while (!arready);
        arvalid <= 0;
        do @(posedge mclk); while (!rvalid);
        d = rdata;
        rready <= 0;
    endtask
    task automatic cmd(input logic [31:0] a, op, output logic [31:0] s);
        axi_wr(32'h4, a);
        axi_wr(32'h0, op);
        s = 32'h1;
        while (s[0] !== 1'b0) axi_rd(32'h10, s);
    endtask
    task automatic t_mode();
        logic [31:0] s;
        s = 0;
        while (s[1] !== 1'b1) axi_rd(32'h10, s);
        chk("mode at init", 32'h20, {18'h0, mdl.mode});
        axi_wr(32'h8, 32'h3e32);
        cmd(0, 5, s);
        chk("mode cleaned", 32'h232, {18'h0, mdl.mode});
        axi_wr(32'h8, 32'h14);
        cmd(0, 5, s);
        chk("bad mode err", 32'h1, {31'h0, s[2]});
        chk("mode kept", 32'h232, {18'h0, mdl.mode});
        axi_wr(32'h10, 32'h4);
        axi_wr(32'h8, 32'h20);
        cmd(0, 5, s);
        chk("mode back", 32'h20, {18'h0, mdl.mode});
        $display("test mode done");
    endtask
    task automatic t_data();
        logic [31:0] s, d;
        cmd(32'h1005, 1, s);
        chk("open banks", 32'h2, {28'h0, s[7:4]});
        axi_wr(32'hc, 32'ha5c3);
        cmd(32'h1003, 2, s);
        chk("stored word", 32'ha5c3, {16'h0, mdl.mem[11'h203]});
        cmd(32'h1003, 3, s);
        axi_rd(32'h14, d);
        chk("read word", 32'ha5c3, {16'h0, d[15:0]});
        axi_wr(32'hc, 32'h3c5a);
        cmd(32'h1007, 32'ha, s);
        chk("ap banks", 32'h0, {28'h0, s[7:4]});
        chk("ap word", 32'h3c5a, {16'h0, mdl.mem[11'h207]});
        chk("model ap banks", 32'h0, {28'h0, mdl.open_bank});
        cmd(32'h1007, 3, s);
        chk("closed err", 32'h1, {31'h0, s[2]});
        $display("test data done");
    endtask
    task automatic t_burst();
        logic [31:0] s, d;
        axi_wr(32'h8, 32'h32);
        cmd(0, 5, s);
        chk("burst mode", 32'h32, {18'h0, mdl.mode});
        cmd(32'h1005, 1, s);
        axi_wr(32'hc, 32'h6e11);
        cmd(32'h1006, 2, s);
        chk("burst word", 32'h6e11, {16'h0, mdl.mem[11'h206]});
        chk("masked beat", 32'h3c5a, {16'h0, mdl.mem[11'h207]});
        cmd(32'h1006, 3, s);
        axi_rd(32'h14, d);
        chk("latency 3 read", 32'h6e11, {16'h0, d[15:0]});
        chk("model banks", 32'h2, {28'h0, mdl.open_bank});
        $display("test burst done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        repeat (3) @(posedge mclk);
        t_mode();
        t_data();
        t_burst();
        complete_run();
    end
endmodule
`default_nettype wire
